// ===== verification/sff_asserts.sv
// Concurrent checks on the pins between the FIFO device and its controller.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ns
module sff_asserts (
   input wire logic clk,
   input wire logic reset,
   input wire logic writeEnableN,
   input wire logic readEnableN,
   input wire logic offsetLoadN,
   input wire logic rewind_pulse,
   input wire logic master_clear_n,
   input wire logic depthCascadeMode,
   input wire logic full_flag_n,
   input wire logic empty_flag_n,
   input wire logic half_full_flag_n,
   input wire logic write_cascade_out,
   input wire logic read_cascade_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_full_blocks_write: assert property (
      !full_flag_n && readEnableN && master_clear_n && !rewind_pulse
      |=> !full_flag_n)
      else $error("write taken while full");
   a_empty_blocks_read: assert property (
      !empty_flag_n && writeEnableN && master_clear_n && !rewind_pulse
      |=> !empty_flag_n)
      else $error("read taken while empty");
   a_clear_empties: assert property (
      !master_clear_n |=> !empty_flag_n && full_flag_n)
      else $error("clear did not empty the fifo");
   a_write_fills_empty: assert property (
      !empty_flag_n && !writeEnableN && offsetLoadN && master_clear_n &&
      !rewind_pulse |=> empty_flag_n)
      else $error("first word did not clear empty");
   a_rewind_refills: assert property (
      rewind_pulse && !depthCascadeMode && master_clear_n |=> empty_flag_n)
      else $error("rewind left fifo empty");
   a_rewind_ports_idle: assert property (
      rewind_pulse |-> (writeEnableN && readEnableN)[*3])
      else $error("port active around rewind");
   a_rewind_single: assert property (
      rewind_pulse |=> !rewind_pulse)
      else $error("rewind pulse too long");
   a_half_has_data: assert property (
      !half_full_flag_n |-> empty_flag_n && master_clear_n)
      else $error("half full while empty");
   a_flags_exclusive: assert property (
      !(!full_flag_n && !empty_flag_n))
      else $error("full and empty together");
   a_cascade_out_quiet: assert property (
      !depthCascadeMode |-> write_cascade_out && read_cascade_out)
      else $error("cascade pulse outside depth cascade");
endmodule

// ===== verification/tb_top.sv
// Self-checking bench: controller and device joined by the pin bundle.
// Assumes a small device depth and a single shared clock.
`timescale 1ns/1ns
module tb_top;
   localparam int D = 16;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        userWrValid = 1'b0;
   logic        userRdReq = 1'b0;
   logic        userProgStart = 1'b0;
   logic        userRewindStart = 1'b0;
   logic [17:0] userWrData = 18'h0_0000;
   logic [15:0] userEmptyOffset = 16'h0003;
   logic [15:0] userFullOffset = 16'h0004;
   wire logic        userWrReady, userRdReady, userRdValid, userBusy;
   wire logic [17:0] userRdData;
   int          err_total = 0;
   int          compares = 0;
   int          n = 127;
   int          m = 127;
   int          rp = 0;
   logic [17:0] mem[$];
   logic [17:0] expq[$];

   sff_if bus ();
   sff_device #(.DEPTH(D)) u_sff_device (.clk, .reset, .link(bus));
   sff_host u_sff_host (.clk, .reset, .link(bus), .userWrValid,
      .userWrData, .userWrReady, .userRdReq, .userRdReady, .userRdValid,
      .userRdData, .userProgStart, .userEmptyOffset, .userFullOffset,
      .userRewindStart, .userBusy);
   sff_asserts u_sff_asserts (.clk, .reset,
      .writeEnableN(bus.writeEnableN), .readEnableN(bus.readEnableN),
      .offsetLoadN(bus.offsetLoadN), .rewind_pulse(bus.rewind_pulse),
      .master_clear_n(bus.master_clear_n),
      .depthCascadeMode(bus.depthCascadeMode),
      .full_flag_n(bus.full_flag_n), .empty_flag_n(bus.empty_flag_n),
      .half_full_flag_n(bus.half_full_flag_n),
      .write_cascade_out(bus.write_cascade_out),
      .read_cascade_out(bus.read_cascade_out));

   always #4 clk = ~clk;

   task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task summarize;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Flags against the modelled count, after the almost flags settle
   task chk;
      int c;
      logic [4:0] e;
      repeat (3) @(posedge clk);
      #1;
      c = mem.size() - rp;
      e = {c != D, !(c > D / 2), !(c + m >= D), !(c <= n), c != 0};
      check("flags", 18'({bus.full_flag_n, bus.half_full_flag_n,
         bus.almost_full_flag_n, bus.almost_empty_flag_n,
         bus.empty_flag_n}), 18'(e));
   endtask

   task put(int k);
      int t;
      repeat (k) begin
         @(posedge clk);
         userWrValid <= 1'b1;
         userWrData <= 18'($urandom);
         #1;
         mem.push_back(userWrData);
         t = 0;
         while (userWrReady !== 1'b1 && t < 50) begin
            @(posedge clk);
            #1;
            t++;
         end
         check("wr wait", 18'(t < 50), 18'h0_0001);
         @(posedge clk);
         userWrValid <= 1'b0;
      end
   endtask

   task get(int k);
      int t;
      repeat (k) begin
         @(posedge clk);
         userRdReq <= 1'b1;
         t = 0;
         #1;
         while (userRdReady !== 1'b1 && t < 50) begin
            @(posedge clk);
            #1;
            t++;
         end
         check("rd wait", 18'(t < 50), 18'h0_0001);
         @(posedge clk);
         userRdReq <= 1'b0;
         expq.push_back(mem[rp]);
         rp++;
      end
   endtask

   // Program offsets or rewind, then wait for the controller to idle
   task op(bit isProg);
      int t;
      @(posedge clk);
      if (isProg) userProgStart <= 1'b1;
      else userRewindStart <= 1'b1;
      @(posedge clk);
      userProgStart <= 1'b0;
      userRewindStart <= 1'b0;
      t = 0;
      #1;
      while (userBusy === 1'b1 && t < 20) begin
         @(posedge clk);
         #1;
         t++;
      end
      check("busy", 18'(userBusy), 18'h0_0000);
      if (!isProg) rp = 0;
   endtask

   always @(posedge clk)
      if (userRdValid === 1'b1)
         check("rdata", userRdData, expq.pop_front());

   initial begin
      #200000;
      err_total++;
      summarize;
   end

   initial begin
      int s;
      s = $urandom(32'h4b18_120e);
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      chk();
      check("rd ready", 18'(userRdReady), 18'h0_0000);
      $display("test reset done");
      for (int i = 1; i <= D; i++) begin
         put(1);
         chk();
      end
      check("wr ready", 18'(userWrReady), 18'h0_0000);
      $display("test fill done");
      op(1);
      n = 3;
      m = 4;
      chk();
      for (int i = D - 1; i >= 0; i--) begin
         get(1);
         chk();
      end
      $display("test drain done");
      repeat (2) begin
         op(0);
         chk();
         get(D);
         chk();
      end
      $display("test rewind done");
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      mem.delete();
      rp = 0;
      n = 127;
      m = 127;
      chk();
      put(5);
      get(2);
      op(0);
      chk();
      put(3);
      chk();
      get(8);
      chk();
      check("left", 18'(expq.size()), 18'h0_0000);
      $display("test reset rewind done");
      summarize;
   end
endmodule

// ===== verilog/sff_device.sv
// FIFO device: storage, pointers, status flags, offsets, rewind, cascade.
// Assumes write and read ports share clk; the controller keeps the
// ports idle around a rewind and never reads or writes during clear.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module sff_device #(
   parameter int unsigned DEPTH = sff_pkg::DEPTH_SMALL
) (
   input wire logic clk,
   input wire logic reset,
   sff_if.device    link
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C   = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_C    = CW'(DEPTH / 2);
   localparam logic [CW-1:0] ZERO_C    = '0;
   localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

   logic [sff_pkg::DATA_W-1:0]   mem [DEPTH];
   logic [AW-1:0]                wrPtr_reg;
   logic [AW-1:0]                rdPtr_reg;
   logic [CW-1:0]                count_reg;
   logic                         wrapped_reg;
   logic [sff_pkg::OFFSET_W-1:0] emptyOff_reg;
   logic [sff_pkg::OFFSET_W-1:0] fullOff_reg;
   logic                         loadSel_reg;
   logic                         readSel_reg;
   logic [sff_pkg::DATA_W-1:0]   readData_reg;
   logic                         full_reg;
   logic                         empty_reg;
   logic                         half_reg;
   logic                         almostFull_reg;
   logic                         almostEmpty_reg;
   logic                         wrToken_reg;
   logic                         rdToken_reg;
   logic                         wrCascOut_reg;
   logic                         rdCascOut_reg;

   // Count at or below the empty offset
   function automatic logic nearEmpty(
      input logic [CW-1:0]                cnt,
      input logic [sff_pkg::OFFSET_W-1:0] off);
      return 32'(cnt) <= 32'(off);
   endfunction

   // Count within the full offset of the depth
   function automatic logic nearFull(
      input logic [CW-1:0]                cnt,
      input logic [sff_pkg::OFFSET_W-1:0] off);
      return (32'(cnt) + 32'(off)) >= DEPTH;
   endfunction

   wire clearAll  = reset || !link.master_clear_n;
   wire cascade   = link.depthCascadeMode;
   wire rewindGo  = link.rewind_pulse && !cascade; // see [R10]
   wire wrReq     = !link.writeEnableN && link.offsetLoadN;
   wire rdReq     = !link.readEnableN && link.offsetLoadN;
   wire progWrite = !link.writeEnableN && !link.offsetLoadN;
   wire progRead  = !link.readEnableN && !link.offsetLoadN;
   // Flag gating of writes and reads
   wire doWrite   = wrReq && full_reg && (!cascade || wrToken_reg)
                    && !rewindGo; // see [R1]
   wire doRead    = rdReq && empty_reg && (!cascade || rdToken_reg)
                    && !rewindGo; // see [R3]
   wire wrLast    = doWrite && (wrPtr_reg == LAST_ADDR);
   wire rdLast    = doRead && (rdPtr_reg == LAST_ADDR);
   // Rewind restores the count of everything stored since clear
   wire [CW-1:0] rewindCount = wrapped_reg ? DEPTH_C
                               : {1'b0, wrPtr_reg}; // see [R14]
   wire [CW-1:0] countNext = rewindGo ? rewindCount
                             : CW'(count_reg + CW'(doWrite)
                                   - CW'(doRead));
   wire [CW-1:0] almostSrc = link.sync_flag_select ? countNext
                             : count_reg; // see [R5]
   wire [sff_pkg::OFFSET_W-1:0] offsetOut = readSel_reg ? fullOff_reg
                                            : emptyOff_reg;
   wire [AW-1:0] wrPtrInc  = AW'(wrPtr_reg + 1'b1);
   wire [AW-1:0] rdPtrInc  = AW'(rdPtr_reg + 1'b1);
   // Next flag levels, all active low
   wire fullNext        = countNext != DEPTH_C; // see [R1] [R2]
   wire emptyNext       = countNext != ZERO_C; // see [R3] [R4]
   wire halfNext        = cascade || !(countNext > HALF_C); // see [R7] [R17]
   wire almostFullNext  = !nearFull(almostSrc, fullOff_reg); // see [R9]
   wire almostEmptyNext = !nearEmpty(almostSrc, emptyOff_reg); // see [R6]
   // Passing a cascade token on after the last location
   wire wrGive          = cascade && wrLast;
   wire rdGive          = cascade && rdLast;

   // Storage is written only by accepted words
   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= link.writeData;
      end
   end

   // Write pointer and the wrap mark that a rewind needs
   always_ff @(posedge clk) begin
      if (clearAll) begin
         wrPtr_reg   <= '0;
         wrapped_reg <= 1'b0;
      end else if (doWrite) begin
         wrPtr_reg   <= wrPtrInc;
         wrapped_reg <= wrapped_reg || wrLast;
      end
   end

   always_ff @(posedge clk) begin
      if (clearAll) begin
         rdPtr_reg <= '0;
      end else if (rewindGo) begin
         rdPtr_reg <= '0; // see [R11] [R16]
      end else if (doRead) begin
         rdPtr_reg <= rdPtrInc; // see [R13]
      end
   end

   always_ff @(posedge clk) begin
      if (clearAll) begin
         count_reg <= ZERO_C; // see [R21]
      end else begin
         count_reg <= countNext;
      end
   end

   // Boundary and half flags from the count after this edge
   always_ff @(posedge clk) begin
      if (clearAll) begin
         full_reg  <= 1'b1;
         empty_reg <= 1'b0; // see [R21]
         half_reg  <= 1'b1;
      end else begin
         full_reg  <= fullNext;
         empty_reg <= emptyNext;
         half_reg  <= halfNext;
      end
   end

   always_ff @(posedge clk) begin
      if (clearAll) begin
         almostFull_reg  <= 1'b1;
         almostEmpty_reg <= 1'b0;
      end else begin
         almostFull_reg  <= almostFullNext;
         almostEmpty_reg <= almostEmptyNext;
      end
   end

   // Offset registers written in alternating order under load
   always_ff @(posedge clk) begin
      if (clearAll) begin
         emptyOff_reg <= sff_pkg::OFFSET_DEFAULT; // see [R8]
         fullOff_reg  <= sff_pkg::OFFSET_DEFAULT;
         loadSel_reg  <= sff_pkg::SEL_EMPTY;
      end else if (progWrite) begin
         loadSel_reg <= !loadSel_reg; // see [R20]
         if (loadSel_reg == sff_pkg::SEL_EMPTY) begin
            emptyOff_reg <= link.writeData[sff_pkg::OFFSET_W-1:0];
         end else begin
            fullOff_reg <= link.writeData[sff_pkg::OFFSET_W-1:0];
         end
      end
   end

   // Output register holds the last valid read when empty
   always_ff @(posedge clk) begin
      if (clearAll) begin
         readData_reg <= '0;
         readSel_reg  <= sff_pkg::SEL_EMPTY;
      end else if (progRead) begin
         readData_reg <= sff_pkg::DATA_W'(offsetOut);
         readSel_reg  <= !readSel_reg;
      end else if (doRead) begin
         readData_reg <= mem[rdPtr_reg];
      end
   end

   // Cascade tokens pass on the last location; taking one wins
   always_ff @(posedge clk) begin
      if (clearAll) begin
         wrToken_reg   <= !link.first_device_select; // see [R18]
         rdToken_reg   <= !link.first_device_select;
         wrCascOut_reg <= 1'b1;
         rdCascOut_reg <= 1'b1;
      end else begin
         wrCascOut_reg <= !wrGive; // see [R19]
         rdCascOut_reg <= !rdGive;
         if (!link.write_cascade_in) begin
            wrToken_reg <= 1'b1;
         end else if (wrGive) begin
            wrToken_reg <= 1'b0;
         end
         if (!link.read_cascade_in) begin
            rdToken_reg <= 1'b1;
         end else if (rdGive) begin
            rdToken_reg <= 1'b0;
         end
      end
   end

   assign link.readData            = readData_reg;
   assign link.full_flag_n         = full_reg;
   assign link.empty_flag_n        = empty_reg;
   assign link.half_full_flag_n    = half_reg;
   assign link.almost_full_flag_n  = almostFull_reg;
   assign link.almost_empty_flag_n = almostEmpty_reg;
   assign link.write_cascade_out   = wrCascOut_reg;
   assign link.read_cascade_out    = rdCascOut_reg;
endmodule

// ===== verilog/sff_host.sv
// Controller end: streams user words in and out, programs offsets,
// issues rewinds with recovery, and pulses the master clear.
// Assumes the device shares clk and answers reads one cycle later.
`timescale 1ns/1ns
module sff_host #(
   parameter logic SYNC_FLAGS_N = 1'b0,
   parameter logic CASCADE_MODE = 1'b0,
   parameter logic NOT_FIRST    = 1'b0
) (
   input  wire logic                         clk,
   input  wire logic                         reset,
   sff_if.host                               link,
   input  wire logic                         userWrValid,
   input  wire logic [sff_pkg::DATA_W-1:0]   userWrData,
   output wire logic                         userWrReady,
   input  wire logic                         userRdReq,
   output wire logic                         userRdReady,
   output wire logic                         userRdValid,
   output wire logic [sff_pkg::DATA_W-1:0]   userRdData,
   input  wire logic                         userProgStart,
   input  wire logic [sff_pkg::OFFSET_W-1:0] userEmptyOffset,
   input  wire logic [sff_pkg::OFFSET_W-1:0] userFullOffset,
   input  wire logic                         userRewindStart,
   output wire logic                         userBusy
);
   localparam logic [sff_pkg::RECOVERY_CNT_W-1:0] RECOVERY_LAST =
      sff_pkg::RECOVERY_CNT_W'(sff_pkg::REWIND_RECOVERY_CYC - 1);

   sff_pkg::sff_host_state_t             state_reg;
   sff_pkg::sff_host_state_t             state_next;
   logic [sff_pkg::OFFSET_W-1:0]         emptyOff_reg;
   logic [sff_pkg::OFFSET_W-1:0]         fullOff_reg;
   logic [sff_pkg::RECOVERY_CNT_W-1:0]   recCnt_reg;
   logic                                 rdValid_reg;
   logic                                 sawRead_reg;

   wire idle      = state_reg == sff_pkg::HST_IDLE;
   wire cmdNow    = userProgStart || userRewindStart;
   // Rewind accepted only once something has been read
   wire rewindOk  = userRewindStart && sawRead_reg; // see [R15]
   wire progEmpty = state_reg == sff_pkg::HST_PROG_EMPTY;
   wire progFull  = state_reg == sff_pkg::HST_PROG_FULL;
   wire prog      = progEmpty || progFull;
   // Streams stop through rewind and recovery
   wire wrGo      = idle && !cmdNow && userWrValid
                    && link.full_flag_n; // see [R12]
   wire rdGo      = idle && !cmdNow && userRdReq && link.empty_flag_n;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sff_pkg::HST_CLEAR: begin
            state_next = sff_pkg::HST_IDLE;
         end
         sff_pkg::HST_IDLE: begin
            if (userProgStart) begin
               state_next = sff_pkg::HST_PROG_EMPTY;
            end else if (rewindOk) begin
               state_next = sff_pkg::HST_REWIND;
            end
         end
         sff_pkg::HST_PROG_EMPTY: begin
            state_next = sff_pkg::HST_PROG_FULL;
         end
         sff_pkg::HST_PROG_FULL: begin
            state_next = sff_pkg::HST_IDLE;
         end
         sff_pkg::HST_REWIND: begin
            state_next = sff_pkg::HST_RECOVER;
         end
         sff_pkg::HST_RECOVER: begin
            if (recCnt_reg == RECOVERY_LAST) begin
               state_next = sff_pkg::HST_IDLE; // see [R12]
            end
         end
         default: begin
            state_next = sff_pkg::HST_CLEAR;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= sff_pkg::HST_CLEAR;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_reg != sff_pkg::HST_RECOVER) begin
         recCnt_reg <= '0;
      end else begin
         recCnt_reg <= sff_pkg::RECOVERY_CNT_W'(recCnt_reg + 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         emptyOff_reg <= sff_pkg::OFFSET_DEFAULT;
         fullOff_reg  <= sff_pkg::OFFSET_DEFAULT;
      end else if (idle && userProgStart) begin
         emptyOff_reg <= userEmptyOffset;
         fullOff_reg  <= userFullOffset;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || state_reg == sff_pkg::HST_CLEAR) begin
         rdValid_reg <= 1'b0;
         sawRead_reg <= 1'b0;
      end else begin
         rdValid_reg <= rdGo;
         sawRead_reg <= sawRead_reg || rdGo;
      end
   end

   assign link.writeData = progEmpty ? sff_pkg::DATA_W'(emptyOff_reg)
                           : progFull ? sff_pkg::DATA_W'(fullOff_reg)
                           : userWrData;
   assign link.writeEnableN        = !(wrGo || prog);
   assign link.readEnableN         = !rdGo;
   assign link.offsetLoadN         = !prog;
   assign link.rewind_pulse        = state_reg == sff_pkg::HST_REWIND;
   assign link.master_clear_n      = state_reg != sff_pkg::HST_CLEAR;
   assign link.sync_flag_select    = SYNC_FLAGS_N;
   assign link.depthCascadeMode    = CASCADE_MODE;
   assign link.first_device_select = NOT_FIRST; // see [R18]
   assign link.write_cascade_in    = 1'b1; // see [R19]
   assign link.read_cascade_in     = 1'b1;

   assign userWrReady = idle && !cmdNow && link.full_flag_n;
   assign userRdReady = idle && !cmdNow && link.empty_flag_n;
   assign userRdValid = rdValid_reg;
   assign userRdData  = link.readData;
   assign userBusy    = !idle;
endmodule

// ===== verilog/sff_if.sv
// Pin bundle between the FIFO device and its controlling logic.
// Assumes both ends run on the same clock; cascade inputs stand in for
// a neighbouring device and are driven by the controller end.
`timescale 1ns/1ns
interface sff_if;
   logic [sff_pkg::DATA_W-1:0] writeData;
   logic                       writeEnableN;
   logic                       readEnableN;
   logic                       offsetLoadN;
   logic                       rewind_pulse;
   logic                       master_clear_n;
   logic                       sync_flag_select;
   logic                       first_device_select;
   logic                       depthCascadeMode;
   logic                       write_cascade_in;
   logic                       read_cascade_in;
   logic [sff_pkg::DATA_W-1:0] readData;
   logic                       full_flag_n;
   logic                       empty_flag_n;
   logic                       almost_full_flag_n;
   logic                       almost_empty_flag_n;
   logic                       half_full_flag_n;
   logic                       write_cascade_out;
   logic                       read_cascade_out;

   modport device (
      input  writeData, writeEnableN, readEnableN, offsetLoadN,
      input  rewind_pulse, master_clear_n, sync_flag_select,
      input  first_device_select, depthCascadeMode,
      input  write_cascade_in, read_cascade_in,
      output readData, full_flag_n, empty_flag_n, almost_full_flag_n,
      output almost_empty_flag_n, half_full_flag_n,
      output write_cascade_out, read_cascade_out
   );

   modport host (
      output writeData, writeEnableN, readEnableN, offsetLoadN,
      output rewind_pulse, master_clear_n, sync_flag_select,
      output first_device_select, depthCascadeMode,
      output write_cascade_in, read_cascade_in,
      input  readData, full_flag_n, empty_flag_n, almost_full_flag_n,
      input  almost_empty_flag_n, half_full_flag_n,
      input  write_cascade_out, read_cascade_out
   );
endinterface

// ===== verilog/sff_pkg.sv
// Shared constants and types for the flagged FIFO and its controller.
// Assumes one clock for both ports and a synchronous active-high reset.
// What this block does
// [R1] Full flag low at depth; writes ignored
// [R2] Full flag updated on write-side clock edges
// [R3] Empty flag low at zero; reads ignored
// [R4] Empty flag updated on read-side clock edges
// [R5] Sync mode: almost flags change on edges
// [R6] Almost empty low while count up to n
// [R7] Half full low above half the depth
// [R8] Both offsets default to 127
// [R9] Almost full low from depth minus m
// [R10] Rewind only honoured when not depth cascaded
// [R11] Rewind returns read pointer to location zero
// [R12] Controller idles both ports around rewind
// [R13] After rewind data replays in order
// [R14] Flags recomputed during rewind; later writes delivered
// [R15] Controller rewinds only after few writes, one read; the controller checks only for the read
// [R16] Full depth rereadable, rewind repeatable
// [R17] Cascade: no half full, flags ORed externally
// [R18] Only first cascaded device selects first
// [R19] Cascade outputs chain to next inputs
// [R20] Two 16-bit offset registers loaded via load
// [R21] Master clear empties FIFO, empty flag low
package sff_pkg;
   localparam int unsigned DATA_W       = 18;
   localparam int unsigned DEPTH_SMALL  = 32768;
   localparam int unsigned DEPTH_LARGE  = 65536;
   localparam int unsigned OFFSET_W     = 16;
   localparam logic [15:0] OFFSET_DEFAULT = 16'h007f;
   localparam logic        SEL_EMPTY    = 1'b0;
   localparam logic        SEL_FULL     = 1'b1;
   localparam int unsigned CLK_PERIOD_NS      = 8;
   localparam int unsigned REWIND_RECOVERY_NS = 10;
   localparam int unsigned REWIND_RECOVERY_CYC =
      (REWIND_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_CNT_W = 8;

   typedef enum logic [2:0] {
      HST_CLEAR,
      HST_IDLE,
      HST_PROG_EMPTY,
      HST_PROG_FULL,
      HST_REWIND,
      HST_RECOVER
   } sff_host_state_t;
endpackage
